/* shared/kbio_pkg.sv */
/*
 * Shared constants for the keyboard controller port and register-space block:
 * the register file map, the program memory map, port layouts and reset values.
 * Assumes one clock and an 8-bit core that reaches the register file by address.
 */
package kbio_pkg;

   // ==========================================================
   // register file map
   localparam logic [7:0] RF_PORT_A    = 8'h00;
   localparam logic [7:0] RF_PORT_B    = 8'h01;
   localparam logic [7:0] RF_PORT_C    = 8'h02;
   localparam logic [7:0] RF_PORT_D    = 8'h03;
   localparam logic [7:0] RF_GP_FIRST  = 8'h04;
   localparam logic [7:0] RF_GP_LAST   = 8'hBF;
   localparam logic [7:0] RF_CTRL_BASE = 8'hF0;
   localparam int         RF_GP_DEPTH  = 188;
   localparam int         RF_CTRL_NUM  = 16;

   // control slots inside F0..FF that hold storage (eleven of them)
   localparam logic [15:0] CTRL_IMPL    = 16'hBEF2;
   localparam logic [3:0]  CTRL_C_MODE  = 4'h6;
   localparam logic [3:0]  CTRL_IRQ_EN  = 4'h7;
   localparam logic [3:0]  CTRL_RPTR    = 4'hD;
   localparam logic [7:0]  RF_RPTR      = 8'hFD;

   // short addressing: groups 0..7 plus the control group F
   localparam logic [3:0] GRP_LAST_LOW = 4'h7;
   localparam logic [3:0] GRP_CTRL     = 4'hF;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_OD_LATCH = 8'hFF;
   localparam logic [7:0] RST_MODE_C   = 8'hFF;
   localparam logic [7:0] RST_ZERO     = 8'h00;

   // ==========================================================
   // program memory map
   localparam logic [15:0] PM_VECTOR_END = 16'h000C;
   localparam int          PM_ROM_LIMIT  = 4096;

   typedef enum logic [1:0] {
      PM_VECTOR,
      PM_ROM,
      PM_RESERVED
   } kbio_pm_region_t;

endpackage

/* verilog/kbio_gp_ram.sv */
/*
 * General-purpose register storage of the register file.
 * Assumes the caller has already turned the register address into a word index;
 * read data appear from a register one clock after the read strobe.
 */
module kbio_gp_ram #(
   parameter int DEPTH = 188,
   parameter int WIDTH = 8,
   parameter int AW    = 8
) (
   input  wire logic             clk,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_idx,
   output logic      [WIDTH-1:0] rd_data_ff
);

   // ==========================================================
   // storage
   // no reset on the array: content after power-up is undefined, as for a real ram
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
      if (rd_en) begin
         rd_data_ff <= mem[rd_idx];
      end
   end

endmodule

/* verilog/kbio_regfile.sv */
/*
 * Port and register-space logic of a small keyboard controller: four 8-bit
 * ports, the register file map with direct and pointer-based short addressing,
 * the program memory map decode and the test clock output.
 * Assumes the core presents one register access per clock, pins are
 * synchronous to clk, and the interrupt controller takes the request pulses.
 */
// What this block does
// - port A eight open-drain lines, never pulled high
// - port B eight open-drain lines from latch
// - mixed port: four fixed inputs, four programmable
// - port D low inputs, high outputs, fixed
// - port D inputs raise four interrupt requests
// - sixteen-bit program address, four kilobyte space
// - lowest twelve program bytes hold vectors
// - six sixteen-bit vectors for five sources
// - rom from twelve to limit, above reserved
// - ports 0-3, general 4-191, control 240-255
// - 188 general and 11 control registers
// - any register reachable by eight-bit address
// - nine working groups of sixteen registers
// - short address joins register pointer group
// - test mode drives system clock out
// - register pointer at FD, read and write
module kbio_regfile
   import kbio_pkg::*;
#(
   parameter int ROM_LIMIT = kbio_pkg::PM_ROM_LIMIT
) (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      acc_short,
   input  wire logic [7:0]                acc_addr,
   input  wire logic                      acc_wr,
   input  wire logic                      acc_rd,
   input  wire logic [7:0]                acc_wdata,
   output logic      [7:0]                acc_rdata_ff,
   output logic                           acc_rvalid_ff,
   output logic                           short_group_bad,
   input  wire logic [15:0]               pm_addr,
   output kbio_pkg::kbio_pm_region_t      pm_region_ff,
   output logic      [2:0]                pm_vector_idx_ff,
   input  wire logic [7:0]                open_drain_port_a_lines_i,
   output logic      [7:0]                open_drain_port_a_lines_o,
   output logic      [7:0]                open_drain_port_a_lines_oe,
   input  wire logic [7:0]                open_drain_port_b_lines_i,
   output logic      [7:0]                open_drain_port_b_lines_o,
   output logic      [7:0]                open_drain_port_b_lines_oe,
   input  wire logic [7:0]                mixed_direction_port_lines_i,
   output logic      [7:0]                mixed_direction_port_lines_o,
   output logic      [7:0]                mixed_direction_port_lines_oe,
   input  wire logic [3:0]                fixed_input_lines,
   output logic      [3:0]                fixed_led_output_lines,
   output logic      [3:0]                external_interrupt_requests,
   input  wire logic                      test_mode_enable,
   output logic                           test_clock_output
);
   import kbio_pkg::*;

   // ==========================================================
   // address formation
   logic [7:0] rptr;
   logic [7:0] eff_addr;
   logic [3:0] grp;

   assign eff_addr = acc_short ? {rptr[7:4], acc_addr[3:0]} : acc_addr;
   assign grp      = rptr[7:4];
   // groups 8..B fall on general space and C..E on unmapped space; flag them all so the core can trap
   assign short_group_bad = acc_short && (grp > GRP_LAST_LOW) && (grp != GRP_CTRL);

   // ==========================================================
   // region decode
   wire sel_port = (eff_addr < RF_GP_FIRST);
   wire sel_gp   = (eff_addr >= RF_GP_FIRST) && (eff_addr <= RF_GP_LAST);
   wire sel_ctrl = (eff_addr >= RF_CTRL_BASE);
   wire [3:0] ctrl_slot = eff_addr[3:0];
   wire [7:0] gp_idx    = eff_addr - RF_GP_FIRST;

   // ==========================================================
   // port latches
   logic [7:0] latch_a_ff, latch_b_ff, latch_c_ff;
   logic [3:0] latch_d_ff;
   wire wr_port = acc_wr && sel_port;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_a_ff <= RST_OD_LATCH;
         latch_b_ff <= RST_OD_LATCH;
         latch_c_ff <= RST_ZERO;
         latch_d_ff <= RST_ZERO[3:0];
      end else if (wr_port) begin
         if (eff_addr == RF_PORT_A) latch_a_ff <= acc_wdata;
         if (eff_addr == RF_PORT_B) latch_b_ff <= acc_wdata;
         if (eff_addr == RF_PORT_C) latch_c_ff <= acc_wdata;
         if (eff_addr == RF_PORT_D) latch_d_ff <= acc_wdata[7:4];
      end
   end

   // ==========================================================
   // control registers: eleven slots hold storage, the rest read zero
   logic [7:0] ctrl_q [RF_CTRL_NUM];
   genvar gi;
   generate
      for (gi = 0; gi < RF_CTRL_NUM; gi++) begin : g_ctrl
         if (CTRL_IMPL[gi]) begin : g_on
            logic [7:0] reg_ff;
            always_ff @(posedge clk or negedge arst_n) begin
               if (!arst_n) begin
                  reg_ff <= (gi == int'(CTRL_C_MODE)) ? RST_MODE_C : RST_ZERO;
               end else if (acc_wr && sel_ctrl && ctrl_slot == 4'(gi)) begin
                  reg_ff <= acc_wdata;
               end
            end
            assign ctrl_q[gi] = reg_ff;
         end else begin : g_off
            assign ctrl_q[gi] = RST_ZERO;
         end
      end
   endgenerate

   wire [7:0] mode_c = ctrl_q[CTRL_C_MODE];
   wire [3:0] irq_en = ctrl_q[CTRL_IRQ_EN][3:0];
   assign rptr = ctrl_q[CTRL_RPTR];

   // ==========================================================
   // pins
   // open drain: the pad is only ever pulled low, a 1 in the latch releases it
   assign open_drain_port_a_lines_o  = RST_ZERO;
   assign open_drain_port_a_lines_oe = ~latch_a_ff;
   assign open_drain_port_b_lines_o  = RST_ZERO;
   assign open_drain_port_b_lines_oe = ~latch_b_ff;

   // low nibble of the mixed port can never drive; mode bit 1 means input
   wire [3:0] c_drive = ~mode_c[7:4];
   assign mixed_direction_port_lines_o  = {latch_c_ff[7:4], 4'h0};
   assign mixed_direction_port_lines_oe = {c_drive, 4'h0};

   assign fixed_led_output_lines = latch_d_ff;

   // the gated clock is only for test; in normal use the pin sits low
   assign test_clock_output = clk & test_mode_enable;

   // ==========================================================
   // external interrupt requests on falling edges of the fixed inputs
   logic [3:0] fin_prev_ff;
   logic [3:0] irq_ff;
   wire  [3:0] fin_fall = fin_prev_ff & ~fixed_input_lines;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fin_prev_ff <= 4'hF;
         irq_ff      <= 4'h0;
      end else begin
         fin_prev_ff <= fixed_input_lines;
         irq_ff      <= fin_fall & irq_en;
      end
   end
   assign external_interrupt_requests = irq_ff;

   // ==========================================================
   // general-purpose storage
   wire gp_wr = acc_wr && sel_gp;
   wire gp_rd = acc_rd && sel_gp;
   logic [7:0] gp_rdata;

   kbio_gp_ram #(
      .DEPTH (RF_GP_DEPTH),
      .WIDTH (8),
      .AW    (8)
   ) u_gp_ram (
      .clk        (clk),
      .wr_en      (gp_wr),
      .wr_idx     (gp_idx),
      .wr_data    (acc_wdata),
      .rd_en      (gp_rd),
      .rd_idx     (gp_idx),
      .rd_data_ff (gp_rdata)
   );

   // ==========================================================
   // read path: one clock of latency; ram word selected after the edge
   wire [7:0] c_rd = (mixed_direction_port_lines_i & {mode_c[7:4], 4'hF})
                   | (latch_c_ff & {c_drive, 4'h0});
   wire [7:0] port_rd = (eff_addr == RF_PORT_A) ? latch_a_ff :
                        (eff_addr == RF_PORT_B) ? latch_b_ff :
                        (eff_addr == RF_PORT_C) ? c_rd :
                        {latch_d_ff, fixed_input_lines};
   wire [7:0] fast_rd = sel_port ? port_rd : (sel_ctrl ? ctrl_q[ctrl_slot] : RST_ZERO);
   logic [7:0] fast_rd_ff;
   logic       gp_sel_ff;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fast_rd_ff    <= RST_ZERO;
         gp_sel_ff     <= 1'b0;
         acc_rvalid_ff <= 1'b0;
      end else begin
         acc_rvalid_ff <= acc_rd;
         if (acc_rd) begin
            fast_rd_ff <= fast_rd;
            gp_sel_ff  <= sel_gp;
         end
      end
   end
   // the ram holds no reset, so its word only shows after a read of gp space
   assign acc_rdata_ff = gp_sel_ff ? gp_rdata : fast_rd_ff;

   // ==========================================================
   // program memory map
   wire pm_vec = (pm_addr < PM_VECTOR_END);
   wire pm_res = (pm_addr >= 16'(ROM_LIMIT));
   kbio_pm_region_t nxt_pm_region;
   assign nxt_pm_region = pm_vec ? PM_VECTOR : (pm_res ? PM_RESERVED : PM_ROM);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pm_region_ff     <= PM_VECTOR;
         pm_vector_idx_ff <= 3'h0;
      end else begin
         pm_region_ff     <= nxt_pm_region;
         pm_vector_idx_ff <= pm_addr[3:1];
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_port_a_low: assert property (open_drain_port_a_lines_o == 8'h00)
      else $error("port a drove a high level");
   a_port_a_drive: assert property ((acc_wr && !acc_short && acc_addr == RF_PORT_A)
      |=> open_drain_port_a_lines_oe == ~$past(acc_wdata))
      else $error("port a enable does not follow latch");
   a_port_b_drive: assert property ((acc_wr && !acc_short && acc_addr == RF_PORT_B)
      |=> open_drain_port_b_lines_oe == ~$past(acc_wdata))
      else $error("port b enable does not follow latch");
   a_mixed_low_in: assert property (mixed_direction_port_lines_oe[3:0] == 4'h0)
      else $error("fixed input half of mixed port driven");
   a_led_write: assert property ((acc_wr && !acc_short && acc_addr == RF_PORT_D)
      |=> fixed_led_output_lines == $past(acc_wdata[7:4]))
      else $error("led outputs did not take written nibble");
   a_irq_edge: assert property ((fin_prev_ff[0] && !fixed_input_lines[0] && irq_en[0])
      |=> external_interrupt_requests[0] ##1 !external_interrupt_requests[0])
      else $error("interrupt request not a single pulse after edge");
   a_vector_map: assert property ((pm_addr < 16'h000C) |=> pm_region_ff == PM_VECTOR)
      else $error("vector area not decoded");
   a_rom_limit: assert property ((pm_addr >= 16'(ROM_LIMIT)) |=> pm_region_ff == PM_RESERVED)
      else $error("address above rom limit not reserved");
   a_rptr_readback: assert property ((acc_wr && !acc_short && acc_addr == RF_RPTR)
      ##1 (acc_rd && !acc_wr && !acc_short && acc_addr == RF_RPTR)
      |=> acc_rvalid_ff && acc_rdata_ff == $past(acc_wdata, 2))
      else $error("register pointer readback mismatch");
   a_short_join: assert property ((acc_short && acc_rd && acc_addr[3:0] == 4'hD && rptr[7:4] == GRP_CTRL)
      |=> acc_rdata_ff == $past(rptr))
      else $error("short address did not reach pointer group");
   a_unmapped_zero: assert property ((acc_rd && !acc_short && acc_addr == 8'hC0) |=> acc_rdata_ff == 8'h00)
      else $error("unmapped register read not zero");
   a_mode_drive: assert property (mixed_direction_port_lines_oe[7:4] == ~mode_c[7:4])
      else $error("mixed line drives while in input mode");

   c_irq: cover property (external_interrupt_requests != 4'h0);
   c_short_rd: cover property (acc_short && acc_rd);
   c_gp_rd: cover property (gp_rd ##1 acc_rvalid_ff);
   c_reserved: cover property (pm_region_ff == PM_RESERVED);

endmodule

/* dv/kbio_keys.sv */
/*
 * keyboard side of the port block: pull-ups, pressed keys, wire levels.
 * assumes each pin arrives split into output, enable and input.
 */
module kbio_keys (
   input  wire logic [7:0] a_o,
   input  wire logic [7:0] a_oe,
   input  wire logic [7:0] b_o,
   input  wire logic [7:0] b_oe,
   input  wire logic [7:0] c_o,
   input  wire logic [7:0] c_oe,
   input  wire logic [7:0] c_press_n,
   input  wire logic [3:0] row_n,
   output logic      [7:0] a_i,
   output logic      [7:0] b_i,
   output logic      [7:0] c_i,
   output logic      [3:0] d_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // wire levels
   // pull-ups lift released port A and B lines; a released port C line follows c_press_n
   assign a_i = (a_oe & a_o) | ~a_oe;
   assign b_i = (b_oe & b_o) | ~b_oe;
   assign c_i = (c_oe & c_o) | (~c_oe & c_press_n);
   assign d_i = row_n;
endmodule

/* dv/kbio_regfile_bench.sv */
/*
 * self-checking bench for the port and register-space block.
 * assumes the key model closes the pins and one access per task call.
 */
module kbio_regfile_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import kbio_pkg::*;
   logic            clk, arst_n, acc_short, acc_wr, acc_rd, tm_en, clk_out;
   logic            acc_rvalid_ff, grp_bad;
   logic [7:0]      acc_addr, acc_wdata, acc_rdata_ff, c_press_n;
   logic [7:0]      a_i, a_o, a_oe, b_i, b_o, b_oe, c_i, c_o, c_oe;
   logic [3:0]      row_n, d_i, leds, irq;
   logic [15:0]     pm_addr;
   logic [2:0]      vidx;
   kbio_pm_region_t region;
   int              miscompares, samples_checked;
   logic [15:0]     pa [6] = '{16'h0000, 16'h000B, 16'h000C, 16'h0FFF, 16'h1000, 16'hFFFF};

   kbio_regfile #(.ROM_LIMIT(4096)) dut (
      .clk(clk), .arst_n(arst_n), .acc_short(acc_short), .acc_addr(acc_addr),
      .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
      .acc_rdata_ff(acc_rdata_ff), .acc_rvalid_ff(acc_rvalid_ff),
      .short_group_bad(grp_bad), .pm_addr(pm_addr), .pm_region_ff(region),
      .pm_vector_idx_ff(vidx), .open_drain_port_a_lines_i(a_i),
      .open_drain_port_a_lines_o(a_o), .open_drain_port_a_lines_oe(a_oe),
      .open_drain_port_b_lines_i(b_i), .open_drain_port_b_lines_o(b_o),
      .open_drain_port_b_lines_oe(b_oe), .mixed_direction_port_lines_i(c_i),
      .mixed_direction_port_lines_o(c_o), .mixed_direction_port_lines_oe(c_oe),
      .fixed_input_lines(d_i), .fixed_led_output_lines(leds),
      .external_interrupt_requests(irq), .test_mode_enable(tm_en),
      .test_clock_output(clk_out));
   kbio_keys keys (
      .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .c_o(c_o), .c_oe(c_oe),
      .c_press_n(c_press_n), .row_n(row_n), .a_i(a_i), .b_i(b_i), .c_i(c_i), .d_i(d_i));

   // ==========================================================
   // shared tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(input logic s, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      acc_short = s;
      acc_wr = w;
      acc_rd = ~w;
      acc_addr = a;
      acc_wdata = d;
      @(negedge clk);
      acc_short = 1'b0;
      acc_wr = 1'b0;
      acc_rd = 1'b0;
   endtask
   task automatic rdc(input logic s, input logic [7:0] a, input logic [7:0] e, input string nm);
      acc(s, 1'b0, a, 8'h00);
      chk("rvalid", 16'(acc_rvalid_ff), 16'h0001);
      chk(nm, 16'(acc_rdata_ff), 16'(e));
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      chk("a_oe", 16'(a_oe), 16'h0000);
      chk("b_oe", 16'(b_oe), 16'h0000);
      chk("c_oe", 16'(c_oe), 16'h0000);
      chk("leds", 16'(leds), 16'h0000);
      rdc(1'b0, RF_PORT_A, 8'hFF, "port_a");
      rdc(1'b0, RF_RPTR, 8'h00, "rptr");
   endtask
   task automatic t_od;
      acc(1'b0, 1'b1, RF_PORT_A, 8'h00);
      acc(1'b0, 1'b1, RF_PORT_B, 8'h5A);
      @(negedge clk);
      chk("a_oe", 16'(a_oe), 16'h00FF);
      chk("a_o", 16'(a_o), 16'h0000);
      chk("b_oe", 16'(b_oe), 16'h00A5);
      chk("b_o", 16'(b_o), 16'h0000);
      rdc(1'b0, RF_PORT_B, 8'h5A, "port_b");
   endtask
   task automatic t_map;
      acc(1'b0, 1'b1, RF_GP_FIRST, 8'h11);
      acc(1'b0, 1'b1, RF_GP_LAST, 8'h22);
      acc(1'b0, 1'b1, 8'hC0, 8'h33);
      acc(1'b0, 1'b1, 8'hF0, 8'h44);
      acc(1'b0, 1'b1, 8'hF1, 8'h55);
      rdc(1'b0, RF_GP_FIRST, 8'h11, "gp_first");
      rdc(1'b0, RF_GP_LAST, 8'h22, "gp_last");
      rdc(1'b0, 8'hC0, 8'h00, "hole");
      rdc(1'b0, 8'hF0, 8'h00, "ctrl_gap");
      rdc(1'b0, 8'hF1, 8'h55, "ctrl_f1");
   endtask
   task automatic t_ptr;
      acc(1'b0, 1'b1, RF_RPTR, 8'h10);
      rdc(1'b0, RF_RPTR, 8'h10, "rptr");
      acc(1'b1, 1'b1, 8'h03, 8'h77);
      rdc(1'b0, 8'h13, 8'h77, "short_wr");
      rdc(1'b1, 8'h03, 8'h77, "short_rd");
      acc(1'b0, 1'b1, RF_RPTR, 8'hF0);
      rdc(1'b1, 8'h0D, 8'hF0, "grp_ctrl");
      acc(1'b0, 1'b1, RF_RPTR, 8'h80);
      @(negedge clk);
      acc_short = 1'b1;
      #1;
      chk("grp_bad", 16'(grp_bad), 16'h0001);
      @(negedge clk);
      acc_short = 1'b0;
   endtask
   task automatic t_mixed;
      // upper two lines output, next two input
      acc(1'b0, 1'b1, 8'hF6, 8'h3F);
      acc(1'b0, 1'b1, RF_PORT_C, 8'hA5);
      c_press_n = 8'h5A;
      @(negedge clk);
      chk("c_oe", 16'(c_oe), 16'h00C0);
      chk("c_o", 16'(c_o), 16'h00A0);
      rdc(1'b0, RF_PORT_C, 8'h9A, "port_c");
   endtask
   task automatic irq_try(input logic [7:0] en, input logic [3:0] press, input logic [3:0] e);
      int         n;
      logic [3:0] got;
      n = 0;
      got = 4'h0;
      acc(1'b0, 1'b1, 8'hF7, en);
      row_n = press;
      repeat (4) begin
         @(negedge clk);
         if (irq !== 4'h0) begin
            n++;
            got = irq;
         end
      end
      chk("irq_count", 16'(n), 16'h0001);
      chk("irq_bits", 16'(got), 16'(e));
      row_n = 4'hF;
      repeat (2) @(negedge clk);
   endtask
   task automatic t_fixed;
      acc(1'b0, 1'b1, RF_PORT_D, 8'hF0);
      @(negedge clk);
      chk("leds", 16'(leds), 16'h000F);
      rdc(1'b0, RF_PORT_D, 8'hFF, "port_d");
      irq_try(8'h01, 4'hC, 4'h1);
      irq_try(8'h0F, 4'h0, 4'hF);
   endtask
   task automatic t_pm;
      logic [15:0] want;
      foreach (pa[i]) begin
         @(negedge clk);
         pm_addr = pa[i];
         want = (pa[i] >= 16'(PM_ROM_LIMIT)) ? 16'(PM_RESERVED) : 16'(PM_ROM);
         if (pa[i] < PM_VECTOR_END) begin
            want = 16'(PM_VECTOR);
         end
         @(negedge clk);
         chk("region", 16'(region), want);
         if (pa[i] < 16'h000C) begin
            chk("vector", 16'(vidx), pa[i] >> 1);
         end
      end
   endtask
   task automatic t_clk;
      @(negedge clk);
      tm_en = 1'b1;
      @(posedge clk);
      #1;
      chk("clk_out_hi", 16'(clk_out), 16'h0001);
      @(negedge clk);
      #1;
      chk("clk_out_lo", 16'(clk_out), 16'h0000);
      @(negedge clk);
      tm_en = 1'b0;
      @(posedge clk);
      #1;
      chk("clk_out_off", 16'(clk_out), 16'h0000);
   endtask

   // ==========================================================
   // clock, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      miscompares = 0;
      samples_checked = 0;
      {arst_n, acc_short, acc_wr, acc_rd, tm_en} = 5'h00;
      acc_addr = 8'h00;
      acc_wdata = 8'h00;
      pm_addr = 16'h0000;
      row_n = 4'hF;
      c_press_n = 8'hFF;
      repeat (5) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      t_reset;
      t_od;
      t_map;
      t_ptr;
      t_mixed;
      t_fixed;
      t_pm;
      t_clk;
      tally_and_finish;
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #50000;
      miscompares++;
      tally_and_finish;
   end
endmodule
